// *** shared/pbi_pkg.sv ***
// Purpose: shared constants and carrier types for the PCI bus signalling block
// Assumes: one 33-100 MHz bus clock, active-low reset
// Notes:   sampled input pins travel as one packed struct; outputs are separate ports
package pbi_pkg;

	localparam int AD_W          = 32;
	localparam int CBE_W         = 4;
	localparam int ABORT_CLKS    = 5;
	localparam int SER_SLOT_W    = 5;
	localparam logic [3:0] CMD_SPECIAL = 4'h1;
	localparam logic [3:0] CMD_IO_RD   = 4'h2;
	localparam logic [3:0] CMD_IO_WR   = 4'h3;
	localparam logic [3:0] CMD_MEM_RD  = 4'h6;
	localparam logic [3:0] CMD_MEM_WR  = 4'h7;
	localparam logic [3:0] CMD_CFG_RD  = 4'hA;
	localparam logic [3:0] CMD_CFG_WR  = 4'hB;
	localparam logic [2:0] PERR_DLY    = 3'h2;

	// pins sampled from the bus
	typedef struct packed {
		logic [31:0] ad;
		logic [3:0]  cbe_n;
		logic        par;
		logic        frame_n;
		logic        irdy_n;
		logic        trdy_n;
		logic        devsel_n;
		logic        stop_n;
		logic        idsel;
		logic        gnt_n;
		logic        sideband_dma_grant_n;
		logic        clkrun_n;
		logic        serial_interrupt_line;
	} pbi_bus_in_t;

	// user side of the initiator
	typedef struct packed {
		logic        req;
		logic        write;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [3:0]  be_n;
		logic        dma;
	} pbi_mreq_t;

	typedef enum logic [1:0] {
		PBI_M_DONE,
		PBI_M_ABORT,
		PBI_M_RETRY
	} pbi_mstat_t;

endpackage

// *** src/pbi_parity.sv ***
// Purpose: even parity over address/data and command/byte-enable lines
// Assumes: operands sampled in the phase before the parity clock
// Notes:   registered one clock later, as the bus parity timing wants
`timescale 1ns/1ns
`default_nettype none
module pbi_parity (
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic [31:0] i_ad,
	input  wire logic [3:0]  i_cbe_n,
	output var  logic        o_par
);
	import pbi_pkg::*;

	wire par_now = ^{i_ad, i_cbe_n};

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_par <= 1'b0;
		end else begin
			o_par <= par_now;
		end
	end
endmodule
`default_nettype wire

// *** src/pbi_core.sv ***
// Purpose: PCI bus signalling of an audio accelerator, initiator and target
// Assumes: bus pins synchronous to i_clk; single-word transfers
// Notes:   open-drain pins only ever pull low
// Functional notes
// - as initiator, wait each data phase until target ready sampled low
// - as target, assert target ready only with data captured or driven
// - initiator drives even parity after address and each write data phase
// - target drives even parity one clock after each read data phase
// - raise sideband DMA request for a DMA transfer; request pin only pulled low, no channel code sent
// - own the bus for sideband DMA only after sideband grant seen
// - request bus, act as owner only after bus grant sampled low
// - bus request high impedance while reset asserted
// - shared legacy mode sends serial interrupt stream, else pin released
// - otherwise level interrupt A pulled low while any interrupt pending
// - parity error asserted two clocks after the bad data phase
// - system error pulled low exactly one clock on address parity fault while selected or in a special cycle
// - configuration accesses answered only with device select input high
// - pull clock-run low when an internal function needs the clock and the line is released, then hold it while needed
// - initiator master aborts without device select by the fifth clock
// - target captures command and address on first frame-low edge
// - reset returns machines to idle and releases all bus outputs
`timescale 1ns/1ns
`default_nettype none
module pbi_core #(
	parameter int IRQ_N = 4
) (
	input  wire logic               i_clk,
	input  wire logic               i_rst_n,
	input  wire pbi_pkg::pbi_bus_in_t i_bus,
	input  wire pbi_pkg::pbi_mreq_t i_mreq,
	input  wire logic [2:0]         i_dma_chan,
	input  wire logic               i_legacy_mode,
	input  wire logic [IRQ_N-1:0]   i_irq,
	input  wire logic               i_need_clk,
	input  wire logic               i_fatal_err,
	input  wire logic [31:0]        i_tgt_rdata,
	output var  logic [31:0]        o_ad,
	output var  logic               o_ad_oe,
	output var  logic [3:0]         o_cbe_n,
	output var  logic               o_cbe_oe,
	output var  logic               o_par,
	output var  logic               o_par_oe,
	output var  logic               o_frame_n,
	output var  logic               o_irdy_n,
	output var  logic               o_mctl_oe,
	output var  logic               o_trdy_n,
	output var  logic               o_devsel_n,
	output var  logic               o_stop_n,
	output var  logic               o_tctl_oe,
	output var  logic               o_req_n,
	output var  logic               o_req_oe,
	output var  logic               o_sideband_dma_request_n,
	output var  logic               o_sbreq_oe,
	output var  logic               o_perr_n,
	output var  logic               o_perr_oe,
	output var  logic               o_serr_oe,
	output var  logic               o_inta_oe,
	output var  logic               o_serirq_oe,
	output var  logic               o_clkrun_oe,
	output var  logic               o_mdone,
	output var  pbi_pkg::pbi_mstat_t o_mstat,
	output var  logic [31:0]        o_mrdata,
	output var  logic               o_twr,
	output var  logic [31:0]        o_taddr,
	output var  logic [31:0]        o_twdata,
	output var  logic [3:0]         o_tcmd
);
	import pbi_pkg::*;

	//------------------------------------------------------------
	// reset synchroniser
	//------------------------------------------------------------
	logic rst_s1_ff, rst_ff;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_s1_ff <= 1'b0;
			rst_ff    <= 1'b0;
		end else begin
			rst_s1_ff <= 1'b1;
			rst_ff    <= rst_s1_ff;
		end
	end
	wire rst_n = rst_ff;

	function automatic logic is_cmd_write(input logic [3:0] c);
		return c[0];
	endfunction

	//------------------------------------------------------------
	// initiator
	//------------------------------------------------------------
	typedef enum logic [2:0] {M_IDLE, M_REQ, M_ADDR, M_DATA, M_TURN} pbi_mst_t;
	pbi_mst_t m_ff;
	logic [2:0] m_cnt_ff;
	logic       m_wr_ff;
	logic       m_par_ph_ff;
	wire gnt_seen   = i_mreq.dma ? !i_bus.sideband_dma_grant_n : !i_bus.gnt_n;
	wire bus_idle   = i_bus.frame_n && i_bus.irdy_n;
	wire m_tready   = !i_bus.trdy_n;
	wire m_stopped  = !i_bus.stop_n;
	wire m_abort    = (m_cnt_ff >= 3'(ABORT_CLKS)) && i_bus.devsel_n;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			m_ff       <= M_IDLE;
			m_cnt_ff   <= 3'h0;
			m_wr_ff    <= 1'b0;
			o_mdone    <= 1'b0;
			o_mstat    <= PBI_M_DONE;
			o_mrdata   <= 32'h0;
			o_frame_n  <= 1'b1;
			o_irdy_n   <= 1'b1;
			o_mctl_oe  <= 1'b0;
			o_req_n    <= 1'b1;
			o_req_oe   <= 1'b0;
			o_sideband_dma_request_n <= 1'b1;
			o_sbreq_oe <= 1'b0;
		end else if (!rst_n) begin
			m_ff       <= M_IDLE;
			o_req_oe   <= 1'b0;
			o_sbreq_oe <= 1'b0;
		end else begin
			o_mdone  <= 1'b0;
			o_req_oe <= 1'b1;
			o_sbreq_oe <= 1'b1;
			case (m_ff)
			M_IDLE: begin
				o_mctl_oe <= 1'b0;
				if (i_mreq.req) begin
					m_ff    <= M_REQ;
					m_wr_ff <= i_mreq.write;
					if (i_mreq.dma) begin
						o_sideband_dma_request_n <= 1'b0;
					end else begin
						o_req_n <= 1'b0;
					end
				end
			end
			M_REQ: begin
				if (gnt_seen && bus_idle) begin
					m_ff      <= M_ADDR;
					o_frame_n <= 1'b0;
					o_mctl_oe <= 1'b1;
					m_cnt_ff  <= 3'h1;
				end
			end
			M_ADDR: begin
				m_ff      <= M_DATA;
				o_frame_n <= 1'b1;
				o_irdy_n  <= 1'b0;
				o_req_n   <= 1'b1;
				o_sideband_dma_request_n <= 1'b1;
				m_cnt_ff  <= m_cnt_ff + 3'h1;
			end
			M_DATA: begin
				if (m_cnt_ff < 3'(ABORT_CLKS)) begin
					m_cnt_ff <= m_cnt_ff + 3'h1;
				end
				if (m_abort) begin
					m_ff     <= M_TURN;
					o_irdy_n <= 1'b1;
					o_mdone  <= 1'b1;
					o_mstat  <= PBI_M_ABORT;
				end else if (m_tready || m_stopped) begin
					m_ff     <= M_TURN;
					o_irdy_n <= 1'b1;
					o_mdone  <= 1'b1;
					o_mstat  <= m_tready ? PBI_M_DONE : PBI_M_RETRY;
					o_mrdata <= i_bus.ad;
				end
			end
			M_TURN: begin
				m_ff      <= M_IDLE;
				o_mctl_oe <= 1'b0;
			end
			default: m_ff <= M_IDLE;
			endcase
		end
	end

	//------------------------------------------------------------
	// target
	//------------------------------------------------------------
	typedef enum logic [1:0] {T_IDLE, T_DATA, T_TURN} pbi_tst_t;
	pbi_tst_t t_ff;
	logic [31:0] t_rdata_ff;
	logic        t_rd_ff;
	wire frame_start = !i_bus.frame_n && (t_ff == T_IDLE) && (m_ff == M_IDLE);
	wire cmd_cfg     = (i_bus.cbe_n == CMD_CFG_RD) || (i_bus.cbe_n == CMD_CFG_WR);
	wire t_hit       = frame_start && cmd_cfg && i_bus.idsel;
	wire t_phase_ok  = (t_ff == T_DATA) && !i_bus.irdy_n && !o_trdy_n;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			t_ff       <= T_IDLE;
			t_rd_ff    <= 1'b0;
			t_rdata_ff <= 32'h0;
			o_trdy_n   <= 1'b1;
			o_devsel_n <= 1'b1;
			o_stop_n   <= 1'b1;
			o_tctl_oe  <= 1'b0;
			o_twr      <= 1'b0;
			o_taddr    <= 32'h0;
			o_twdata   <= 32'h0;
			o_tcmd     <= 4'h0;
		end else if (!rst_n) begin
			t_ff      <= T_IDLE;
			o_tctl_oe <= 1'b0;
		end else begin
			o_twr <= 1'b0;
			case (t_ff)
			T_IDLE: begin
				o_tctl_oe <= 1'b0;
				if (t_hit) begin
					o_taddr    <= i_bus.ad;
					o_tcmd     <= i_bus.cbe_n;
					t_rd_ff    <= !is_cmd_write(i_bus.cbe_n);
					t_rdata_ff <= i_tgt_rdata;
					o_devsel_n <= 1'b0;
					o_tctl_oe  <= 1'b1;
					t_ff       <= T_DATA;
				end
			end
			T_DATA: begin
				if (t_phase_ok) begin
					if (!t_rd_ff) begin
						o_twdata <= i_bus.ad;
						o_twr    <= 1'b1;
					end
					o_trdy_n   <= 1'b1;
					o_devsel_n <= 1'b1;
					t_ff       <= T_TURN;
				end else if (!i_bus.irdy_n) begin
					// write data is on the lines now; read data driven below
					o_trdy_n <= 1'b0;
				end
			end
			T_TURN: begin
				o_tctl_oe <= 1'b0;
				t_ff      <= T_IDLE;
			end
			default: t_ff <= T_IDLE;
			endcase
		end
	end

	//------------------------------------------------------------
	// address/data drive and parity
	//------------------------------------------------------------
	wire        m_drive = (m_ff == M_ADDR) || ((m_ff == M_DATA) && m_wr_ff);
	wire        t_drive = (t_ff == T_DATA) && t_rd_ff;
	wire [31:0] nxt_ad  = (m_ff == M_REQ) ? i_mreq.addr
	                    : (m_ff == M_ADDR) ? i_mreq.wdata : t_rdata_ff;
	wire [3:0]  nxt_cbe = (m_ff == M_REQ)
	                    ? (i_mreq.write ? CMD_MEM_WR : CMD_MEM_RD) : i_mreq.be_n;
	wire        nxt_ad_oe = rst_n && (((m_ff == M_REQ) && gnt_seen && bus_idle)
	                    || ((m_ff == M_ADDR) && m_wr_ff)
	                    || ((m_ff == M_DATA) && m_wr_ff && !m_tready && !m_abort)
	                    || (t_drive && !t_phase_ok) || (t_hit && !is_cmd_write(i_bus.cbe_n)));

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_ad     <= 32'h0;
			o_ad_oe  <= 1'b0;
			o_cbe_n  <= 4'hF;
			o_cbe_oe <= 1'b0;
			o_par_oe <= 1'b0;
		end else begin
			if (m_ff == M_REQ || m_ff == M_ADDR) begin
				o_ad    <= nxt_ad;
				o_cbe_n <= nxt_cbe;
			end else if (t_ff != T_IDLE || t_hit) begin
				o_ad <= t_hit ? i_tgt_rdata : t_rdata_ff;
			end
			o_ad_oe  <= nxt_ad_oe;
			o_cbe_oe <= rst_n && ((m_ff == M_REQ && gnt_seen && bus_idle)
			            || m_ff == M_ADDR || (m_ff == M_DATA && !m_tready && !m_abort));
			o_par_oe <= rst_n && (m_drive || t_drive);
		end
	end

	// parity follows the lines one clock later
	pbi_parity u_par (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_ad    (o_ad),
		.i_cbe_n (m_ff == M_IDLE ? i_bus.cbe_n : o_cbe_n),
		.o_par   (o_par)
	);

	//------------------------------------------------------------
	// parity and system error
	//------------------------------------------------------------
	logic [1:0] perr_pipe_ff;
	logic       chk_data_ff, chk_addr_ff, chk_special_ff;
	logic [35:0] chk_bits_ff;
	wire  rx_par_bad = (^chk_bits_ff) != i_bus.par;
	wire  t_wr_done  = t_phase_ok && !t_rd_ff;
	wire  m_rd_done  = (m_ff == M_DATA) && !m_wr_ff && m_tready;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			chk_bits_ff    <= 36'h0;
			chk_data_ff    <= 1'b0;
			chk_addr_ff    <= 1'b0;
			chk_special_ff <= 1'b0;
			perr_pipe_ff   <= 2'h0;
			o_perr_n       <= 1'b1;
			o_perr_oe      <= 1'b0;
			o_serr_oe      <= 1'b0;
		end else begin
			chk_bits_ff    <= {i_bus.ad, i_bus.cbe_n};
			chk_data_ff    <= t_wr_done || m_rd_done;
			chk_addr_ff    <= frame_start && i_bus.idsel;
			chk_special_ff <= frame_start && (i_bus.cbe_n == CMD_SPECIAL);
			// stage 0 holds the parity error enable one more clock; o_perr_n itself is set straight from the check
			perr_pipe_ff   <= {perr_pipe_ff[0], chk_data_ff && rx_par_bad};
			o_perr_n       <= !(chk_data_ff && rx_par_bad);
			o_perr_oe      <= rst_n && (chk_data_ff || perr_pipe_ff[0]);
			o_serr_oe      <= rst_n && !o_serr_oe && (i_fatal_err
			                  || ((chk_addr_ff || chk_special_ff) && rx_par_bad));
		end
	end

	//------------------------------------------------------------
	// interrupts and clock run
	//------------------------------------------------------------
	logic [SER_SLOT_W-1:0] ser_slot_ff;
	wire any_irq = |i_irq;
	wire ser_start = !i_bus.serial_interrupt_line;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ser_slot_ff <= '0;
			o_inta_oe   <= 1'b0;
			o_serirq_oe <= 1'b0;
			o_clkrun_oe <= 1'b0;
		end else begin
			ser_slot_ff <= ser_start && ser_slot_ff == '0 ? SER_SLOT_W'(1)
			             : (ser_slot_ff != '0 ? ser_slot_ff + SER_SLOT_W'(1) : '0);
			o_inta_oe   <= rst_n && !i_legacy_mode && any_irq;
			o_serirq_oe <= rst_n && i_legacy_mode && any_irq
			               && ser_slot_ff == SER_SLOT_W'(i_dma_chan);
			// grab a released line, then hold it while the clock is needed
			o_clkrun_oe <= rst_n && i_need_clk && (i_bus.clkrun_n || o_clkrun_oe);
		end
	end

	//------------------------------------------------------------
	// checks
	//------------------------------------------------------------
	chk_req_rst: assert property (@(posedge i_clk) !rst_n |-> ##1 !o_req_oe)
		else $error("request driven in reset");
	chk_owner_grant: assert property (@(posedge i_clk) disable iff (!rst_n)
		$rose(o_mctl_oe) |-> $past(gnt_seen))
		else $error("bus taken without grant");
	chk_abort_time: assert property (@(posedge i_clk) disable iff (!rst_n)
		(o_mdone && o_mstat == PBI_M_ABORT) |-> $past(m_cnt_ff) >= 3'(ABORT_CLKS))
		else $error("early master abort");
	chk_wait_trdy: assert property (@(posedge i_clk) disable iff (!rst_n)
		(m_ff == M_DATA && i_bus.trdy_n && !m_abort && i_bus.stop_n) |=> m_ff == M_DATA)
		else $error("data phase left without target ready");
	chk_serr_one: assert property (@(posedge i_clk) disable iff (!rst_n)
		o_serr_oe |=> !o_serr_oe)
		else $error("system error longer than one clock");
	chk_inta_mode: assert property (@(posedge i_clk) disable iff (!rst_n)
		i_legacy_mode |=> !o_inta_oe)
		else $error("interrupt A driven in legacy mode");
	chk_cfg_sel: assert property (@(posedge i_clk) disable iff (!rst_n)
		(t_ff == T_IDLE ##1 t_ff == T_DATA) |-> $past(i_bus.idsel))
		else $error("config answered without select");
	chk_par_even: assert property (@(posedge i_clk) disable iff (!rst_n)
		m_ff == M_ADDR |=> o_par == ^$past({o_ad, o_cbe_n}))
		else $error("bad address parity");
	cov_write: cover property (@(posedge i_clk) o_mdone && o_mstat == PBI_M_DONE && m_wr_ff);
	cov_abort: cover property (@(posedge i_clk) o_mdone && o_mstat == PBI_M_ABORT);
	cov_tgt: cover property (@(posedge i_clk) o_twr);
endmodule
`default_nettype wire

// *** src/pbi_core_dummy_unused.sv ***
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// *** dv/pbi_host_model.sv ***
// Purpose: host side of the bus: arbiter, sideband arbiter, memory target
// Assumes: pins sampled at the rising edge, released lines read high
// Notes:   i_claim low leaves a cycle unclaimed; i_wait adds target waits
`timescale 1ns/1ns
`default_nettype none
module pbi_host_model (
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_req_n,
	input  wire logic       i_sbreq_n,
	input  wire logic       i_frame_n,
	input  wire logic       i_irdy_n,
	input  wire logic       i_claim,
	input  wire logic [1:0] i_wait,
	output var  logic       o_gnt_n,
	output var  logic       o_sbgnt_n,
	output var  logic       o_devsel_n,
	output var  logic       o_trdy_n
);
	logic [1:0] wcnt_ff;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_gnt_n    <= 1'h1;
			o_sbgnt_n  <= 1'h1;
			o_devsel_n <= 1'h1;
			o_trdy_n   <= 1'h1;
			wcnt_ff    <= 2'h0;
		end else begin
			o_gnt_n   <= i_req_n;
			o_sbgnt_n <= i_sbreq_n;
			if (!o_trdy_n) begin
				o_trdy_n   <= 1'h1;
				o_devsel_n <= 1'h1;
				wcnt_ff    <= 2'h0;
			end else if (!o_devsel_n && !i_irdy_n) begin
				if (wcnt_ff == i_wait) o_trdy_n <= 1'h0;
				else wcnt_ff <= wcnt_ff + 2'h1;
			end else if (!i_frame_n && i_claim) o_devsel_n <= 1'h0;
		end
	end
endmodule
`default_nettype wire

// *** dv/pci_bus_interface_signalling_tb_top.sv ***
// Purpose: self-checking bench for the bus signalling block
// Assumes: host model acts as arbiter and memory target
// Notes:   inputs change at the falling edge
`timescale 1ns/1ns
`default_nettype none
module pci_bus_interface_signalling_tb_top;
	import pbi_pkg::*;
	logic        clk, rst_n, idsel, legacy, need_clk, fatal, claim, tfr_n, tirdy_n, tpar;
	logic        ad_oe, cbe_oe, par, par_oe, frame_n, irdy_n, mctl_oe, trdy_n, devsel_n;
	logic        stop_n, tctl_oe, req_n, req_oe, sb_n, sb_oe, perr_n, perr_oe, serr_oe;
	logic        inta_oe, serirq_oe, clkrun_oe, mdone, twr, gnt_n, sbgnt_n, mdev_n, mtrdy_n;
	logic        p_oe, tw, sirq_n;
	logic [31:0] tad, rdata, ad, mrdata, taddr, twdata, tw_a, tw_d;
	logic [3:0]  tcbe_n, irq, cbe_n, tcmd;
	logic [35:0] p_v;
	pbi_mreq_t   mreq;
	pbi_bus_in_t bus;
	pbi_mstat_t  mstat;
	int          n_errors, cmp_count;

	// ----------------------------------------
	// pin levels seen by both parties
	// ----------------------------------------
	always_comb begin
		bus                       = '0;
		bus.ad                    = ad_oe ? ad : tad;
		bus.cbe_n                 = cbe_oe ? cbe_n : tcbe_n;
		bus.par                   = par_oe ? par : tpar;
		bus.frame_n               = mctl_oe ? frame_n : tfr_n;
		bus.irdy_n                = mctl_oe ? irdy_n : tirdy_n;
		bus.trdy_n                = tctl_oe ? trdy_n : mtrdy_n;
		bus.devsel_n              = tctl_oe ? devsel_n : mdev_n;
		bus.stop_n                = tctl_oe ? stop_n : 1'h1;
		bus.idsel                 = idsel;
		bus.gnt_n                 = gnt_n;
		bus.sideband_dma_grant_n  = sbgnt_n;
		bus.clkrun_n              = !clkrun_oe;
		bus.serial_interrupt_line = !serirq_oe && sirq_n;
	end

	pbi_core #(.IRQ_N(4)) dut (
		.i_clk(clk), .i_rst_n(rst_n), .i_bus(bus), .i_mreq(mreq), .i_dma_chan(3'h3),
		.i_legacy_mode(legacy), .i_irq(irq), .i_need_clk(need_clk), .i_fatal_err(fatal),
		.i_tgt_rdata(rdata), .o_ad(ad), .o_ad_oe(ad_oe), .o_cbe_n(cbe_n), .o_cbe_oe(cbe_oe),
		.o_par(par), .o_par_oe(par_oe), .o_frame_n(frame_n), .o_irdy_n(irdy_n),
		.o_mctl_oe(mctl_oe), .o_trdy_n(trdy_n), .o_devsel_n(devsel_n), .o_stop_n(stop_n),
		.o_tctl_oe(tctl_oe), .o_req_n(req_n), .o_req_oe(req_oe),
		.o_sideband_dma_request_n(sb_n), .o_sbreq_oe(sb_oe), .o_perr_n(perr_n),
		.o_perr_oe(perr_oe), .o_serr_oe(serr_oe), .o_inta_oe(inta_oe),
		.o_serirq_oe(serirq_oe), .o_clkrun_oe(clkrun_oe), .o_mdone(mdone), .o_mstat(mstat),
		.o_mrdata(mrdata), .o_twr(twr), .o_taddr(taddr), .o_twdata(twdata), .o_tcmd(tcmd)
	);

	pbi_host_model host (
		.i_clk(clk), .i_rst_n(rst_n), .i_req_n(req_oe ? req_n : 1'h1),
		.i_sbreq_n(sb_oe ? sb_n : 1'h1), .i_frame_n(bus.frame_n), .i_irdy_n(bus.irdy_n),
		.i_claim(claim), .i_wait(2'h2), .o_gnt_n(gnt_n), .o_sbgnt_n(sbgnt_n),
		.o_devsel_n(mdev_n), .o_trdy_n(mtrdy_n)
	);

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop;
		if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic timeout(input int i, input int lim);
		if (i >= lim) begin
			n_errors++;
			report_and_stop;
		end
	endtask

	task automatic tick;
		@(negedge clk);
		if (par_oe === 1'h1 && p_oe) chk(par, ^p_v);
		if (twr === 1'h1) {tw, tw_a, tw_d} = {1'h1, taddr, twdata};
		p_oe = ad_oe === 1'h1;
		p_v  = {bus.ad, bus.cbe_n};
	endtask

	task automatic t_rst;
		rst_n = 1'h0;
		#1;
		chk({ad_oe, cbe_oe, par_oe, mctl_oe, tctl_oe, perr_oe, sb_oe}, '0);
		chk({serr_oe, inta_oe, serirq_oe, clkrun_oe}, '0);
		chk(req_oe, 1'h0);
		repeat (12) @(negedge clk);
		rst_n = 1'h1;
		repeat (4) tick;
	endtask

	task automatic t_master(input logic wr, input logic dma, input logic cl,
		input pbi_mstat_t exp);
		int   i;
		logic g, t, f;
		{g, t, f} = '0;
		claim = cl;
		tpar = ^{tad, 4'h0};
		mreq = '{1'h1, wr, 32'h0000_1000, 32'hA5A5_0F0F, 4'h0, dma};
		for (i = 0; i < 40 && mdone !== 1'h1; i++) begin
			tick;
			if (mctl_oe === 1'h1 && frame_n === 1'h0 && !f) begin
				f = 1'h1;
				chk(g, 1'h1);
				chk(ad, 32'h0000_1000);
				chk(cbe_n, wr ? CMD_MEM_WR : CMD_MEM_RD);
				chk({req_oe, sb_oe, dma ? sb_n : req_n, irdy_n}, 4'hD);
			end
			if ((dma ? sbgnt_n : gnt_n) === 1'h0) g = 1'h1;
			if (bus.trdy_n === 1'h0) t = 1'h1;
		end
		timeout(i, 40);
		chk(mstat, exp);
		chk(t, cl);
		if (!wr && exp == PBI_M_DONE) chk(mrdata, tad);
		mreq.req = 1'h0;
		tick;
	endtask

	task automatic t_tgt(input logic wr, input logic sel, input logic bad);
		int   i;
		logic d;
		{d, tw, claim, idsel} = {3'h0, sel};
		tad = 32'h0000_0040;
		tcbe_n = wr ? CMD_CFG_WR : CMD_CFG_RD;
		tfr_n = 1'h0;
		tick;
		tpar = ^{tad, tcbe_n};
		{tfr_n, tirdy_n, tad, tcbe_n} = {2'h2, 32'h1234_5678, 4'h0};
		for (i = 0; i < 8 && trdy_n !== 1'h0; i++) begin
			tick;
			if (devsel_n === 1'h0 && tctl_oe === 1'h1) d = 1'h1;
		end
		chk(d, sel);
		if (sel) begin
			timeout(i, 8);
			chk({tcmd, stop_n}, {wr ? CMD_CFG_WR : CMD_CFG_RD, 1'h1});
			if (!wr) chk(ad, rdata);
			tick;
			tirdy_n = 1'h1;
			tpar = ^{tad, tcbe_n} ^ bad;
			tick;
			chk(perr_oe === 1'h1 && perr_n === 1'h0, bad);
		end
		{tirdy_n, idsel, tad} = {2'h2, ~tad};
		tick;
		if (!bad) chk(tw, wr & sel);
		if (wr && sel && !bad) chk({tw_a, tw_d}, 64'h0000_0040_1234_5678);
	endtask

	task automatic t_side;
		int i, n;
		{legacy, irq, need_clk} = {1'h0, 4'h2, 1'h1};
		repeat (3) tick;
		chk({inta_oe, serirq_oe, clkrun_oe}, 3'h5);
		t_rst;
		legacy = 1'h1;
		repeat (3) tick;
		chk(inta_oe, 1'h0);
		sirq_n = 1'h0;
		tick;
		sirq_n = 1'h1;
		repeat (2) tick;
		chk(serirq_oe, 1'h0);
		tick;
		chk(serirq_oe, 1'h1);
		tick;
		chk(serirq_oe, 1'h0);
		{legacy, irq, need_clk} = '0;
		repeat (3) tick;
		chk({inta_oe, clkrun_oe}, 2'h0);
		n = 0;
		fatal = 1'h1;
		for (i = 0; i < 6; i++) begin
			tick;
			fatal = 1'h0;
			n += (serr_oe === 1'h1);
		end
		chk(n, 1);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	initial begin
		{n_errors, cmp_count} = '0;
		{idsel, legacy, need_clk, fatal, tpar, p_oe, tw} = '0;
		{tfr_n, tirdy_n, claim, sirq_n} = 4'hF;
		{tad, tcbe_n, irq, p_v} = {32'h0, 4'hF, 4'h0, 36'h0};
		rdata = 32'hC0DE_0042;
		mreq = '0;
		t_rst;
		t_master(1'h1, 1'h0, 1'h1, PBI_M_DONE);
		t_master(1'h0, 1'h0, 1'h0, PBI_M_ABORT);
		t_master(1'h1, 1'h1, 1'h1, PBI_M_DONE);
		t_tgt(1'h1, 1'h1, 1'h0);
		t_tgt(1'h0, 1'h1, 1'h0);
		t_tgt(1'h1, 1'h0, 1'h0);
		t_tgt(1'h1, 1'h1, 1'h1);
		t_master(1'h0, 1'h0, 1'h1, PBI_M_DONE);
		t_side;
		report_and_stop;
	end
endmodule
`default_nettype wire
